// [logic/gpib_remote_local_control.sv]
module gpib_remote_local_control (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] bus_data,
	input wire logic bus_byte_valid,
	input wire logic atn,
	input wire logic ren,
	input wire logic ifc,
	input wire logic [4:0] cfg_addr,
	input wire logic cfg_addr_load,
	input wire logic one_shot_bus_trigger_mode,
	input wire logic [7:0] panel_keys,
	input wire logic local_key,
	output logic remote_lamp,
	output logic talk_lamp,
	output logic listen_lamp,
	output logic talk_enable,
	output logic [7:0] panel_keys_out,
	output logic restore_defaults,
	output logic start_conversion,
	output logic [4:0] primary_addr
);
	import bus_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [11:0] pins_raw;
	logic [11:0] pins_sync;
	logic [7:0] s_data;
	logic s_valid;
	logic s_atn;
	logic s_ren;
	logic s_ifc;

	assign pins_raw = {bus_data, bus_byte_valid, atn, ren, ifc};

	pin_sync #(
		.WIDTH(12)
	) u_pin_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);

	assign s_data = pins_sync[11:4];
	assign s_valid = pins_sync[3];
	assign s_atn = pins_sync[2];
	assign s_ren = pins_sync[1];
	assign s_ifc = pins_sync[0];

	////////////////////////////////////////////////////////////////
	// Byte strobe edge detect
	logic valid_d_ff;
	logic nxt_valid_d;
	logic cmd_take;

	always_comb begin
		nxt_valid_d = s_valid;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			valid_d_ff <= 1'b0;
		end else begin
			valid_d_ff <= nxt_valid_d;
		end
	end

	assign cmd_take = s_valid && !valid_d_ff && s_atn;

	////////////////////////////////////////////////////////////////
	// Command byte decode
	logic hit_gtl;
	logic hit_sdc;
	logic hit_get;
	logic hit_llo;
	logic hit_dcl;
	logic hit_unl;
	logic hit_unt;

	assign hit_gtl = cmd_take && s_data == CMD_GTL;
	assign hit_sdc = cmd_take && s_data == CMD_SDC;
	assign hit_get = cmd_take && s_data == CMD_GET;
	assign hit_llo = cmd_take && s_data == CMD_LLO;
	assign hit_dcl = cmd_take && s_data == CMD_DCL;
	assign hit_unl = cmd_take && s_data == CMD_UNL;
	assign hit_unt = cmd_take && s_data == CMD_UNT;

	////////////////////////////////////////////////////////////////
	// Local key press detect
	logic key_d_ff;
	logic nxt_key_d;
	logic key_press;

	always_comb begin
		nxt_key_d = local_key;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			key_d_ff <= 1'b0;
		end else begin
			key_d_ff <= nxt_key_d;
		end
	end

	assign key_press = local_key && !key_d_ff;

	////////////////////////////////////////////////////////////////
	// Addressed state and primary address
	logic [4:0] addr_ff;
	logic [4:0] nxt_addr;
	logic listen_ff;
	logic nxt_listen;
	logic talk_ff;
	logic nxt_talk;
	logic [2:0] grp;
	logic [4:0] byte_addr;
	logic is_my_listen;
	logic is_my_talk;

	assign grp = s_data[GRP_HI:GRP_LO];
	assign byte_addr = s_data[ADDR_HI:0];
	assign is_my_listen = cmd_take && grp == GRP_LISTEN && byte_addr == addr_ff;
	assign is_my_talk = cmd_take && grp == GRP_TALK && byte_addr == addr_ff;

	always_comb begin
		nxt_addr = addr_ff;
		nxt_listen = listen_ff;
		nxt_talk = talk_ff;
		if (cfg_addr_load && cfg_addr <= ADDR_MAX) begin
			nxt_addr = cfg_addr;
		end
		if (s_ifc) begin
			nxt_listen = 1'b0;
			nxt_talk = 1'b0;
		end else if (cmd_take) begin
			if (hit_unl) begin
				nxt_listen = 1'b0;
			end else if (hit_unt) begin
				nxt_talk = 1'b0;
			end else if (is_my_listen) begin
				nxt_listen = 1'b1;
				nxt_talk = 1'b0;
			end else if (is_my_talk) begin
				nxt_talk = 1'b1;
				nxt_listen = 1'b0;
			end else if (grp == GRP_TALK) begin
				nxt_talk = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			addr_ff <= ADDR_DEFAULT;
			listen_ff <= 1'b0;
			talk_ff <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			listen_ff <= nxt_listen;
			talk_ff <= nxt_talk;
		end
	end

	////////////////////////////////////////////////////////////////
	// Remote / local state machine
	rl_state_t rl_ff;
	rl_state_t nxt_rl;
	logic llo_ff;
	logic nxt_llo;
	logic gtl_hit;

	assign gtl_hit = hit_gtl && listen_ff;

	always_comb begin
		nxt_rl = rl_ff;
		nxt_llo = llo_ff;
		if (hit_llo) begin
			nxt_llo = 1'b1;
		end
		if (!s_ren) begin
			nxt_llo = 1'b0;
			nxt_rl = ST_LOCAL;
		end else begin
			case (rl_ff)
				ST_LOCAL: begin
					if (is_my_listen) begin
						nxt_rl = (llo_ff || nxt_llo) ? ST_LOCKED : ST_REMOTE;
					end
				end
				ST_REMOTE: begin
					if (gtl_hit) begin
						nxt_rl = ST_LOCAL;
					end else if (nxt_llo) begin
						nxt_rl = ST_LOCKED;
					end else if (key_press) begin
						nxt_rl = ST_LOCAL;
					end
				end
				ST_LOCKED: begin
					if (gtl_hit) begin
						nxt_rl = ST_LOCAL;
					end
				end
				default: begin
					nxt_rl = ST_LOCAL;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rl_ff <= ST_LOCAL;
			llo_ff <= 1'b0;
		end else begin
			rl_ff <= nxt_rl;
			llo_ff <= nxt_llo;
		end
	end

	////////////////////////////////////////////////////////////////
	// Panel key gating, one gate per key
	logic panel_open;
	logic [7:0] keys_gated;

	assign panel_open = nxt_rl == ST_LOCAL;

	for (genvar k = 0; k < 8; k++) begin : g_key_gate
		assign keys_gated[k] = panel_keys[k] && panel_open;
	end

	////////////////////////////////////////////////////////////////
	// Clear and trigger pulses, registered outputs
	logic nxt_remote_lamp;
	logic [7:0] nxt_panel_keys_out;
	logic nxt_restore_defaults;
	logic nxt_start_conversion;

	always_comb begin
		nxt_remote_lamp = nxt_rl != ST_LOCAL;
		nxt_panel_keys_out = keys_gated;
		nxt_restore_defaults = hit_dcl;
		if (hit_sdc && listen_ff) begin
			nxt_restore_defaults = 1'b1;
		end
		nxt_start_conversion = hit_get && listen_ff && one_shot_bus_trigger_mode;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			remote_lamp <= 1'b0;
			talk_lamp <= 1'b0;
			listen_lamp <= 1'b0;
			talk_enable <= 1'b0;
			panel_keys_out <= 8'h00;
			restore_defaults <= 1'b0;
			start_conversion <= 1'b0;
			primary_addr <= ADDR_DEFAULT;
		end else begin
			remote_lamp <= nxt_remote_lamp;
			talk_lamp <= nxt_talk;
			listen_lamp <= nxt_listen;
			talk_enable <= nxt_talk;
			panel_keys_out <= nxt_panel_keys_out;
			restore_defaults <= nxt_restore_defaults;
			start_conversion <= nxt_start_conversion;
			primary_addr <= nxt_addr;
		end
	end
endmodule // gpib_remote_local_control

// [include/bus_ctrl_pkg.sv]
package bus_ctrl_pkg;
	// Interface command byte codes, received with ATN asserted
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_UNL = 8'h3F;
	localparam logic [7:0] CMD_UNT = 8'h5F;
	// Address group decode
	localparam logic [2:0] GRP_LISTEN = 3'h1;
	localparam logic [2:0] GRP_TALK = 3'h2;
	localparam int GRP_HI = 7;
	localparam int GRP_LO = 5;
	localparam int ADDR_HI = 4;
	localparam logic [4:0] ADDR_DEFAULT = 5'h16;
	localparam logic [4:0] ADDR_MAX = 5'h1E;
	// Synchroniser stages on the bus pins; pin_sync fixes two stages and does not read this
	localparam int SYNC_STAGES = 2;
	// Remote/local states
	typedef enum logic [1:0] {
		ST_LOCAL = 2'b00,
		ST_REMOTE = 2'b01,
		ST_LOCKED = 2'b10
	} rl_state_t;
endpackage

// [logic/pin_sync.sv]
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] nxt_stage1;
	logic [WIDTH-1:0] nxt_stage2;

	////////////////////////////////////////////////////////////////
	// Two flip-flop synchroniser
	always_comb begin
		nxt_stage1 = async_in;
		nxt_stage2 = stage1_ff;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign sync_out = stage2_ff;
endmodule // pin_sync

// [tb/gpib_rlc_props.sv]
module gpib_rlc_props (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ren,
	input wire logic ifc,
	input wire logic atn,
	input wire logic one_shot_bus_trigger_mode,
	input wire logic remote_lamp,
	input wire logic talk_lamp,
	input wire logic listen_lamp,
	input wire logic talk_enable,
	input wire logic [7:0] panel_keys_out,
	input wire logic restore_defaults,
	input wire logic start_conversion,
	input wire logic [4:0] primary_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	import bus_ctrl_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_reset_values: assert property (
		$fell(sys_rst) |-> primary_addr == ADDR_DEFAULT && !remote_lamp && !talk_lamp) else $error("reset values");
	a_talk_any_state: assert property (
		talk_enable == talk_lamp) else $error("talk enable");
	a_panel_blocked: assert property (
		remote_lamp && $past(remote_lamp) |-> panel_keys_out == 8'h00) else $error("panel not blocked");
	a_ifc_idles: assert property (
		ifc [*5] |=> !talk_lamp && !listen_lamp) else $error("ifc idle");
	a_ren_low_local: assert property (
		!ren [*5] |=> !remote_lamp) else $error("ren low remote");
	a_clear_pulse: assert property (
		restore_defaults |=> !restore_defaults) else $error("clear pulse");
	a_trig_mode: assert property (
		start_conversion |-> one_shot_bus_trigger_mode) else $error("trigger mode");
	a_trig_listener: assert property (
		start_conversion |-> listen_lamp ##1 !start_conversion) else $error("trigger listener");
	a_addr_range: assert property (
		primary_addr <= ADDR_MAX) else $error("address range");
	a_remote_needs_ren: assert property (
		$rose(remote_lamp) |-> $past(ren, 3)) else $error("remote without ren");
	a_listen_needs_atn: assert property (
		$rose(listen_lamp) |-> $past(atn, 3)) else $error("listen without atn");
endmodule // gpib_rlc_props
bind gpib_remote_local_control gpib_rlc_props i_gpib_rlc_props (.core_clk, .sys_rst, .ren, .ifc, .atn,
	.one_shot_bus_trigger_mode, .remote_lamp, .talk_lamp, .listen_lamp, .talk_enable, .panel_keys_out,
	.restore_defaults, .start_conversion, .primary_addr);

// [tb/ctl_model.sv]
module ctl_model (
	input wire logic core_clk,
	output logic [7:0] bus_data,
	output logic bus_byte_valid,
	output logic atn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_data = 8'h00;
		bus_byte_valid = 1'b0;
		atn = 1'b0;
	end
	task automatic send(input logic [7:0] b, input logic a);
		@(posedge core_clk);
		bus_data <= b;
		atn <= a;
		repeat (2) @(posedge core_clk);
		bus_byte_valid <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus_byte_valid <= 1'b0;
		repeat (2) @(posedge core_clk);
		bus_data <= ~b;
		repeat (4) @(posedge core_clk);
	endtask
endmodule // ctl_model

// [tb/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bus_ctrl_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ren = 1'b0, ifc = 1'b0, cfg_addr_load = 1'b0, one_shot_bus_trigger_mode = 1'b0, local_key = 1'b0;
	logic [4:0] cfg_addr = 5'h00;
	logic [7:0] panel_keys = 8'hFF;
	logic [7:0] bus_data, panel_keys_out;
	logic bus_byte_valid, atn, remote_lamp, talk_lamp, listen_lamp, talk_enable, restore_defaults, start_conversion;
	logic [4:0] primary_addr;
	int miscompares = 0, check_count = 0, n_rd = 0, n_sc = 0;
	logic [8:0] cmd [8] = '{9'h036, 9'h136, 9'h156, 9'h15F, 9'h136, 9'h101, 9'h13F, 9'h156};
	logic [2:0] exp_rlt [8] = '{3'h0, 3'h6, 3'h5, 3'h4, 3'h6, 3'h2, 3'h0, 3'h1};
	always #4 core_clk = ~core_clk;
	ctl_model i_ctl_model (.core_clk, .bus_data, .bus_byte_valid, .atn);
	gpib_remote_local_control i_gpib_remote_local_control (.core_clk, .sys_rst, .bus_data, .bus_byte_valid,
		.atn, .ren, .ifc, .cfg_addr, .cfg_addr_load, .one_shot_bus_trigger_mode, .panel_keys, .local_key,
		.remote_lamp, .talk_lamp, .listen_lamp, .talk_enable, .panel_keys_out, .restore_defaults,
		.start_conversion, .primary_addr);
	always @(posedge core_clk) begin
		n_rd += int'(restore_defaults === 1'b1);
		n_sc += int'(start_conversion === 1'b1);
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp_v);
		check_count++;
		if (seen !== exp_v) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp_v, seen);
		end
	endtask
	task automatic tx(input logic [8:0] c);
		i_ctl_model.send(c[7:0], c[8]);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		ren <= 1'b1;
		@(posedge core_clk);
		check("addr", 8'(primary_addr), 8'(ADDR_DEFAULT));
		for (int i = 0; i < 8; i++) begin
			tx(cmd[i]);
			check("remote", 8'(remote_lamp), 8'(exp_rlt[i][2]));
			check("listen", 8'(listen_lamp), 8'(exp_rlt[i][1]));
			check("talk", 8'(talk_enable), 8'(exp_rlt[i][0]));
		end
		$display("table done");
		tx({1'b1, CMD_UNT});
		tx({1'b1, CMD_UNL});
		tx(9'h136);
		tx({1'b1, CMD_SDC});
		one_shot_bus_trigger_mode <= 1'b1;
		tx({1'b1, CMD_GET});
		one_shot_bus_trigger_mode <= 1'b0;
		tx({1'b1, CMD_GET});
		tx({1'b1, CMD_UNL});
		one_shot_bus_trigger_mode <= 1'b1;
		tx({1'b1, CMD_GET});
		tx({1'b1, CMD_SDC});
		tx({1'b1, CMD_DCL});
		check("conv", 8'(n_sc), 8'h01);
		check("clear", 8'(n_rd), 8'h02);
		$display("trigger done");
		tx(9'h136);
		tx({1'b1, CMD_LLO});
		local_key <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("locked", 8'(remote_lamp), 8'h01);
		check("keys", panel_keys_out, 8'h00);
		tx({1'b1, CMD_GTL});
		check("keys", panel_keys_out, 8'hFF);
		tx(9'h136);
		check("relock", 8'(remote_lamp), 8'h01);
		ren <= 1'b0;
		local_key <= 1'b0;
		repeat (6) @(posedge core_clk);
		check("ren off", 8'(remote_lamp), 8'h00);
		tx(9'h136);
		check("ren low listen", 8'(remote_lamp), 8'h00);
		ren <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("ren alone", 8'(remote_lamp), 8'h00);
		tx(9'h136);
		check("remote keys", panel_keys_out, 8'h00);
		local_key <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("local key", 8'(remote_lamp), 8'h00);
		$display("lockout done");
		tx(9'h156);
		check("talk", 8'(talk_lamp), 8'h01);
		ifc <= 1'b1;
		repeat (12500) @(posedge core_clk);
		ifc <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("idle", {6'h00, talk_lamp, listen_lamp}, 8'h00);
		cfg_addr <= 5'h1F;
		cfg_addr_load <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("addr refused", 8'(primary_addr), 8'(ADDR_DEFAULT));
		cfg_addr <= ADDR_MAX;
		@(posedge core_clk);
		cfg_addr_load <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("addr", 8'(primary_addr), 8'(ADDR_MAX));
		tx({1'b1, GRP_LISTEN, ADDR_MAX});
		check("listen", 8'(listen_lamp), 8'h01);
		check("held key", 8'(remote_lamp), 8'h01);
		$display("address done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		check("reset addr", 8'(primary_addr), 8'(ADDR_DEFAULT));
		check("reset remote", 8'(remote_lamp), 8'h00);
		check("reset listen", 8'(listen_lamp), 8'h00);
		$display("reset done");
		finish_test();
	end
endmodule // tb
